// ### dsc_config_regs.sv
// Write-only configuration bank of a dual fractional-N synthesizer, loaded over
// a three-wire serial port, with reference dividers and a monitor multiplexer.
// Assumes serial pins and the reference oscillator are asynchronous and slow
// compared with core_clk.
`timescale 1ns/1ps

// Notes on behaviour
// R01 - Aux divider holds nine-bit index
// R02 - Host loads nearest divide value minus 32
// R03 - Aux fraction holds ten-bit signed offset
// R04 - Main ref index low, aux next
// R05 - Reference dividers divide by index plus one
// R06 - Reference indices reset to zero
// R07 - Five-bit main detector gain field
// R08 - Five-bit aux detector gain field
// R09 - Main pin: lock indicator or steering
// R10 - Aux pin: lock indicator or steering
// R11 - Full power-down spares oscillator, serial, monitor
// R12 - Main power-down bit controls main synthesizer
// R13 - Main mode bit selects integer-N
// R14 - Fractionality bit selects modulator size
// R15 - Aux power-down bit controls aux synthesizer
// R16 - Aux mode bit selects integer-N
// R17 - Three-bit select drives monitor pin
// R18 - Tri-state bit releases monitor pin
// R19 - No write or power-up ordering needed
// R20 - Monitor select encoding in bits 8..6
// R21 - Address first, data next, MSB first
// R22 - Aux divider resets 0x006, others zero
// R23 - Registers update only on complete write
module dsc_config_regs (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   serClk,
  input  wire logic                   serSelN,
  input  wire logic                   serData,
  input  wire logic                   refOsc,
  input  wire logic                   main_detector_freq,
  input  wire logic                   aux_detector_freq,
  input  wire logic                   mainLocked,
  input  wire logic                   auxLocked,
  input  wire logic                   mainSteer,
  input  wire logic                   auxSteer,
  output logic [8:0]                  auxDivIndex,
  output logic [9:0]                  auxFraction,
  output logic [4:0]                  mainRefIndex,
  output logic [4:0]                  auxRefIndex,
  output logic [4:0]                  mainGain,
  output logic [4:0]                  auxGain,
  output logic                        mainPowerDown,
  output logic                        auxPowerDown,
  output logic                        fullPowerDown,
  output logic                        mainIntegerMode,
  output logic                        auxIntegerMode,
  output logic                        mainFrac10Bit,
  output logic                        refMainOut,
  output logic                        refAuxOut,
  output logic                        main_lock_steer_pin_o,
  output logic                        main_lock_steer_pin_oe,
  output logic                        aux_lock_steer_pin_o,
  output logic                        aux_lock_steer_pin_oe,
  output logic                        monitorOut,
  output logic                        monitorOutEn
);
  import dsc_pkg::*;

  // Next reference counter value, wrapping at the programmed index
  function automatic logic [4:0] refCountNext(input logic [4:0] cnt, input logic [4:0] idx);
    refCountNext = (cnt >= idx) ? 5'h00 : cnt + 5'h01;
  endfunction : refCountNext

  // High for the first half of the divide period, rounded up
  function automatic logic refHigh(input logic [4:0] cnt, input logic [4:0] idx);
    logic [5:0] ratio;
    ratio   = {1'b0, idx} + 6'h01;
    refHigh = ({1'b0, cnt} < ((ratio + 6'h01) >> 1));
  endfunction : refHigh

  // Two-stage synchronisers for all asynchronous inputs
  logic [5:0] syncA_reg;
  logic [5:0] syncB_reg;
  logic [5:0] syncC_reg;
  logic       sClk;
  logic       sSelN;
  logic       sData;
  logic       sOsc;
  logic       sPdMain;
  logic       sPdAux;
  logic       serRise;
  logic       selRise;
  logic       selFall;
  logic       oscRise;
  // Analog levels: bit 0 main lock, 1 aux lock, 2 main steer, 3 aux steer
  logic [3:0] anaA_reg;
  logic [3:0] anaB_reg;

  // Select resets high, its idle level, so no false select edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_reg <= 6'h02;
      syncB_reg <= 6'h02;
      syncC_reg <= 6'h02;
      anaA_reg  <= 4'h0;
      anaB_reg  <= 4'h0;
    end else begin
      syncA_reg <= {aux_detector_freq, main_detector_freq, refOsc, serData, serSelN, serClk};
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      anaA_reg  <= {auxSteer, mainSteer, auxLocked, mainLocked};
      anaB_reg  <= anaA_reg;
    end
  end

  assign sClk    = syncB_reg[0];
  assign sSelN   = syncB_reg[1];
  assign sData   = syncB_reg[2];
  assign sOsc    = syncB_reg[3];
  assign sPdMain = syncB_reg[4];
  assign sPdAux  = syncB_reg[5];
  assign serRise = sClk & ~syncC_reg[0];
  assign selRise = sSelN & ~syncC_reg[1];
  assign selFall = ~sSelN & syncC_reg[1];
  assign oscRise = sOsc & ~syncC_reg[3];

  // R21 shift address then data, MSB first
  logic [15:0] shift_reg;
  logic [4:0]  bitCount_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg    <= 16'h0000;
      bitCount_reg <= 5'h00;
    end else if (selFall) begin
      bitCount_reg <= 5'h00;
    end else if (!sSelN && serRise) begin
      shift_reg <= {shift_reg[14:0], sData};
      if (bitCount_reg != 5'h1F) begin
        bitCount_reg <= bitCount_reg + 5'h01;
      end
    end
  end

  // R23 commit only a complete frame at select release
  logic       frameDone;
  logic [3:0] frameAddr;
  logic [11:0] frameData;

  assign frameDone = selRise && (bitCount_reg == FRAME_COUNT);
  assign frameAddr = shift_reg[FRAME_BITS-1 -: ADDR_BITS];
  assign frameData = shift_reg[DATA_BITS-1:0];

  // R22 reset values; R19 registers independent of write order
  logic [11:0] auxDiv_reg;
  logic [11:0] auxFrac_reg;
  logic [11:0] refDiv_reg;
  logic [11:0] gain_reg;
  logic [11:0] power_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      auxDiv_reg  <= RST_AUX_DIV;
      auxFrac_reg <= RST_ZERO;
      refDiv_reg  <= RST_ZERO;
      gain_reg    <= RST_ZERO;
      power_reg   <= RST_ZERO;
    end else if (frameDone) begin
      case (frameAddr)
        ADDR_AUX_DIV:  auxDiv_reg  <= frameData;
        ADDR_AUX_FRAC: auxFrac_reg <= frameData;
        ADDR_REF_DIV:  refDiv_reg  <= frameData;
        ADDR_GAIN:     gain_reg    <= frameData;
        ADDR_POWER:    power_reg   <= frameData;
        default: begin
        end
      endcase
    end
  end

  // R01 nine-bit aux divider index
  assign auxDivIndex     = auxDiv_reg[AUX_DIV_MSB:0];
  // R03 ten-bit two's complement fraction
  assign auxFraction     = auxFrac_reg[AUX_FRAC_MSB:0];
  // R04 reference index fields
  assign mainRefIndex    = refDiv_reg[REF_MAIN_LSB +: 5];
  assign auxRefIndex     = refDiv_reg[REF_AUX_LSB +: 5];
  // R07 main detector gain
  assign mainGain        = gain_reg[GAIN_MAIN_LSB +: 5];
  // R08 aux detector gain
  assign auxGain         = gain_reg[GAIN_AUX_LSB +: 5];
  // R11 full power-down flag
  assign fullPowerDown   = power_reg[FULL_PD_BIT];
  // R12 main power-down, also by full power-down
  assign mainPowerDown   = power_reg[MAIN_PD_BIT] | power_reg[FULL_PD_BIT];
  // R15 aux power-down, also by full power-down
  assign auxPowerDown    = power_reg[AUX_PD_BIT] | power_reg[FULL_PD_BIT];
  // R13 main integer-N mode
  assign mainIntegerMode = power_reg[MAIN_MODE_BIT];
  // R16 aux integer-N mode
  assign auxIntegerMode  = power_reg[AUX_MODE_BIT];
  // R14 modulator size select
  assign mainFrac10Bit   = power_reg[FRACT_BIT];

  // R05 reference dividers counting oscillator edges
  logic [4:0] mainCnt_reg;
  logic [4:0] auxCnt_reg;
  logic       refMain_reg;
  logic       refAux_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mainCnt_reg <= 5'h00;
    end else if (mainPowerDown) begin
      mainCnt_reg <= 5'h00;
    end else if (oscRise) begin
      mainCnt_reg <= refCountNext(mainCnt_reg, mainRefIndex);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      auxCnt_reg <= 5'h00;
    end else if (auxPowerDown) begin
      auxCnt_reg <= 5'h00;
    end else if (oscRise) begin
      auxCnt_reg <= refCountNext(auxCnt_reg, auxRefIndex);
    end
  end

  // R06 index zero passes the oscillator undivided
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      refMain_reg <= 1'b0;
      refAux_reg  <= 1'b0;
    end else begin
      if (mainPowerDown) begin
        refMain_reg <= 1'b0;
      end else if (mainRefIndex == 5'h00) begin
        refMain_reg <= sOsc;
      end else begin
        refMain_reg <= refHigh(mainCnt_reg, mainRefIndex);
      end
      if (auxPowerDown) begin
        refAux_reg <= 1'b0;
      end else if (auxRefIndex == 5'h00) begin
        refAux_reg <= sOsc;
      end else begin
        refAux_reg <= refHigh(auxCnt_reg, auxRefIndex);
      end
    end
  end

  assign refMainOut = refMain_reg;
  assign refAuxOut  = refAux_reg;

  // Lock and steering pins
  logic mainPinO_reg;
  logic mainPinOe_reg;
  logic auxPinO_reg;
  logic auxPinOe_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mainPinO_reg  <= 1'b0;
      mainPinOe_reg <= 1'b0;
      auxPinO_reg   <= 1'b0;
      auxPinOe_reg  <= 1'b0;
    end else begin
      // R09 main pin steering or open-collector lock
      if (gain_reg[STEER_MAIN_BIT]) begin
        mainPinO_reg  <= anaB_reg[2];
        mainPinOe_reg <= ~mainPowerDown;
      end else begin
        mainPinO_reg  <= 1'b0;
        mainPinOe_reg <= anaB_reg[0] & ~mainPowerDown;
      end
      // R10 aux pin steering or open-collector lock
      if (gain_reg[STEER_AUX_BIT]) begin
        auxPinO_reg  <= anaB_reg[3];
        auxPinOe_reg <= ~auxPowerDown;
      end else begin
        auxPinO_reg  <= 1'b0;
        auxPinOe_reg <= anaB_reg[1] & ~auxPowerDown;
      end
    end
  end

  assign main_lock_steer_pin_o  = mainPinO_reg;
  assign main_lock_steer_pin_oe = mainPinOe_reg;
  assign aux_lock_steer_pin_o   = auxPinO_reg;
  assign aux_lock_steer_pin_oe  = auxPinOe_reg;

  // R17 R20 monitor multiplexer, alive in full power-down
  dsc_mux_type muxSel;
  logic        monitor_reg;
  logic        monitorEn_reg;

  assign muxSel = dsc_mux_type'(power_reg[MUX_SEL_LSB +: 3]);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      monitor_reg <= 1'b0;
    end else begin
      case (muxSel)
        MUX_REF_OSC:   monitor_reg <= sOsc;
        MUX_REF_AUX:   monitor_reg <= refAux_reg;
        MUX_REF_MAIN:  monitor_reg <= refMain_reg;
        MUX_PD_AUX:    monitor_reg <= sPdAux & ~auxPowerDown;
        MUX_PD_MAIN:   monitor_reg <= sPdMain & ~mainPowerDown;
        MUX_SDATA_OUT: monitor_reg <= shift_reg[FRAME_BITS-1];
        MUX_TEST_OUT:  monitor_reg <= frameDone;
        default:       monitor_reg <= 1'b0;
      endcase
    end
  end

  // R18 tri-state control of monitor pin
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      monitorEn_reg <= 1'b1;
    end else begin
      monitorEn_reg <= ~power_reg[MUX_TRI_BIT];
    end
  end

  assign monitorOut   = monitor_reg;
  assign monitorOutEn = monitorEn_reg;

endmodule : dsc_config_regs

// ### dsc_pkg.sv
// Constants for the dual synthesizer configuration bank.
// Assumes a three-wire serial host and a core clock far faster than the serial clock.
package dsc_pkg;

  // Serial frame layout
  localparam int          FRAME_BITS     = 16;
  localparam int          ADDR_BITS      = 4;
  localparam int          DATA_BITS      = 12;
  localparam logic [4:0]  FRAME_COUNT    = 5'h10;

  // Register addresses
  localparam logic [3:0]  ADDR_AUX_DIV   = 4'h3;
  localparam logic [3:0]  ADDR_AUX_FRAC  = 4'h4;
  localparam logic [3:0]  ADDR_REF_DIV   = 4'h5;
  localparam logic [3:0]  ADDR_GAIN      = 4'h6;
  localparam logic [3:0]  ADDR_POWER     = 4'h7;

  // Reset values
  localparam logic [11:0] RST_AUX_DIV    = 12'h006;
  localparam logic [11:0] RST_ZERO       = 12'h000;

  // Field positions
  localparam int          AUX_DIV_MSB    = 8;
  localparam int          AUX_FRAC_MSB   = 9;
  localparam int          REF_MAIN_LSB   = 0;
  localparam int          REF_AUX_LSB    = 5;
  localparam int          GAIN_MAIN_LSB  = 0;
  localparam int          STEER_MAIN_BIT = 5;
  localparam int          GAIN_AUX_LSB   = 6;
  localparam int          STEER_AUX_BIT  = 11;
  localparam int          FULL_PD_BIT    = 0;
  localparam int          MAIN_PD_BIT    = 1;
  localparam int          MAIN_MODE_BIT  = 2;
  localparam int          FRACT_BIT      = 3;
  localparam int          AUX_PD_BIT     = 4;
  localparam int          AUX_MODE_BIT   = 5;
  localparam int          MUX_SEL_LSB    = 6;
  localparam int          MUX_TRI_BIT    = 9;

  // Monitor multiplexer codes
  typedef enum logic [2:0] {
    MUX_REF_OSC   = 3'h0,
    MUX_REF_AUX   = 3'h1,
    MUX_REF_MAIN  = 3'h2,
    MUX_PD_AUX    = 3'h3,
    MUX_PD_MAIN   = 3'h4,
    MUX_SDATA_OUT = 3'h5,
    MUX_TEST_OUT  = 3'h6,
    MUX_UNUSED    = 3'h7
  } dsc_mux_type;

endpackage : dsc_pkg

// ### dsc_config_regs_properties.sv
// Port assertions for the configuration bank.
// Assumes serial select is slow next to core_clk.
`timescale 1ns/1ps
module dsc_config_regs_chk (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       serSelN,
  input wire logic       mainSteer,
  input wire logic       auxSteer,
  input wire logic [8:0] auxDivIndex,
  input wire logic [9:0] auxFraction,
  input wire logic [4:0] mainRefIndex,
  input wire logic [4:0] auxRefIndex,
  input wire logic [4:0] mainGain,
  input wire logic [4:0] auxGain,
  input wire logic       mainPowerDown,
  input wire logic       auxPowerDown,
  input wire logic       fullPowerDown,
  input wire logic       mainIntegerMode,
  input wire logic       auxIntegerMode,
  input wire logic       mainFrac10Bit,
  input wire logic       refMainOut,
  input wire logic       refAuxOut,
  input wire logic       main_lock_steer_pin_o,
  input wire logic       main_lock_steer_pin_oe,
  input wire logic       aux_lock_steer_pin_o,
  input wire logic       monitorOutEn
);
  import dsc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0]  idleCnt;
  logic [44:0] cfg;
  assign cfg = {auxDivIndex, auxFraction, mainRefIndex, auxRefIndex, mainGain, auxGain,
                mainPowerDown, auxPowerDown, fullPowerDown, mainIntegerMode,
                auxIntegerMode, mainFrac10Bit};
  // Cycles since the select was last low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) idleCnt <= 4'h0;
    else if (!serSelN) idleCnt <= 4'h0;
    else if (idleCnt != 4'hF) idleCnt <= idleCnt + 4'h1;
  end
  AST_RESET_VALUES: assert property ($rose(arst_n) |-> auxDivIndex == RST_AUX_DIV[8:0]
    && mainRefIndex == 5'h00 && auxRefIndex == 5'h00 && monitorOutEn)
    else $error("bad values after reset");
  AST_FIELDS_STABLE: assert property (idleCnt >= 4'h8 |-> $stable(cfg))
    else $error("field changed without a frame");
  AST_FULL_PD_MAIN: assert property (fullPowerDown |-> mainPowerDown)
    else $error("full power-down left main up");
  AST_FULL_PD_AUX: assert property (fullPowerDown |-> auxPowerDown)
    else $error("full power-down left aux up");
  AST_MAIN_OE_PD: assert property ($past(mainPowerDown, 2) && $past(mainPowerDown)
    && mainPowerDown |-> !main_lock_steer_pin_oe) else $error("main pin driven in power-down");
  AST_REF_MAIN_PD: assert property (mainPowerDown [*3] |-> !refMainOut)
    else $error("main reference runs in power-down");
  AST_REF_AUX_PD: assert property (auxPowerDown [*3] |-> !refAuxOut)
    else $error("aux reference runs in power-down");
  AST_MAIN_STEER_O: assert property (main_lock_steer_pin_o |-> $past(mainSteer, 3))
    else $error("main pin high without steering");
  AST_AUX_STEER_O: assert property (aux_lock_steer_pin_o |-> $past(auxSteer, 3))
    else $error("aux pin high without steering");
endmodule : dsc_config_regs_chk

bind dsc_config_regs dsc_config_regs_chk chk (.core_clk, .arst_n, .serSelN, .mainSteer,
  .auxSteer, .auxDivIndex, .auxFraction, .mainRefIndex, .auxRefIndex, .mainGain, .auxGain,
  .mainPowerDown, .auxPowerDown, .fullPowerDown, .mainIntegerMode, .auxIntegerMode,
  .mainFrac10Bit, .refMainOut, .refAuxOut, .main_lock_steer_pin_o, .main_lock_steer_pin_oe,
  .aux_lock_steer_pin_o, .monitorOutEn);

// ### dsc_host_model.sv
// Host model writing frames on the three-wire port.
// Assumes the bank samples the pins with its own clock.
`timescale 1ns/1ps
module dsc_host_model (
  output logic serClk,
  output logic serSelN,
  output logic serData
);
  initial begin
    serClk  = 1'b0;
    serSelN = 1'b1;
    serData = 1'b1;
  end
  task automatic send(input logic [15:0] frame, input int nBits);
    serSelN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      serData = (i < 16) ? frame[15 - i] : 1'b0;
      #62.5 serClk = 1'b1;
      #62.5 serClk = 1'b0;
    end
    #62.5 serSelN = 1'b1;
    serData = ~serData;
    #125;
  endtask : send
endmodule : dsc_host_model

// ### testbench.sv
// Self-checking bench for the configuration bank.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
module testbench;
  import dsc_pkg::*;
  logic       core_clk, arst_n, refOsc, mainLocked, auxLocked, mainSteer, auxSteer;
  logic       serClk, serSelN, serData;
  logic [8:0] auxDivIndex;
  logic [9:0] auxFraction;
  logic [4:0] mainRefIndex, auxRefIndex, mainGain, auxGain;
  logic       mainPowerDown, auxPowerDown, fullPowerDown, mainIntegerMode, auxIntegerMode;
  logic       mainFrac10Bit, refMainOut, refAuxOut, monitorOut, monitorOutEn;
  logic       mainPinO, mainPinOe, auxPinO, auxPinOe;
  logic       main_detector_freq, aux_detector_freq;
  int         miscompares = 0;
  int         total_checks = 0;

  dsc_host_model host (.serClk, .serSelN, .serData);
  dsc_config_regs DUT (.core_clk, .arst_n, .serClk, .serSelN, .serData, .refOsc,
    .main_detector_freq, .aux_detector_freq, .mainLocked, .auxLocked,
    .mainSteer, .auxSteer, .auxDivIndex, .auxFraction, .mainRefIndex, .auxRefIndex,
    .mainGain, .auxGain, .mainPowerDown, .auxPowerDown, .fullPowerDown, .mainIntegerMode,
    .auxIntegerMode, .mainFrac10Bit, .refMainOut, .refAuxOut,
    .main_lock_steer_pin_o(mainPinO), .main_lock_steer_pin_oe(mainPinOe),
    .aux_lock_steer_pin_o(auxPinO), .aux_lock_steer_pin_oe(auxPinOe), .monitorOut,
    .monitorOutEn);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    refOsc = 1'b0;
    forever #32 refOsc = ~refOsc;
  end

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [11:0] d, input int n = 16);
    host.send({a, d}, n);
    repeat (6) @(negedge core_clk);
  endtask : wr

  task automatic ratio(input int src, input int exp);
    realtime t1;
    realtime t2;
    if (src == 0) begin
      @(posedge refMainOut) t1 = $realtime;
      @(posedge refMainOut) t2 = $realtime;
    end else if (src == 1) begin
      @(posedge refAuxOut) t1 = $realtime;
      @(posedge refAuxOut) t2 = $realtime;
    end else begin
      @(posedge monitorOut) t1 = $realtime;
      @(posedge monitorOut) t2 = $realtime;
    end
    @(negedge core_clk);
    check((src == 0) ? "mainRatio" : (src == 1) ? "auxRatio" : "monitorRatio", 12'(exp),
      12'(int'((t2 - t1) / 64.0)));
  endtask : ratio

  task automatic t_reset();
    check("auxDivIndex", RST_AUX_DIV, 12'(auxDivIndex));
    check("refIndices", RST_ZERO, 12'({mainRefIndex, auxRefIndex}));
    ratio(1'b0, 1);
    ratio(1'b1, 1);
  endtask : t_reset

  task automatic t_aux();
    wr(ADDR_AUX_DIV, 12'(8'h32 - 8'h20));
    check("auxDivIndex", 12'h012, 12'(auxDivIndex));
    wr(ADDR_AUX_DIV, 12'h1F9);
    check("auxDivIndex", 12'h1F9, 12'(auxDivIndex));
    wr(ADDR_AUX_DIV, 12'hFFF);
    check("auxDivIndex", 12'h1FF, 12'(auxDivIndex));
    wr(ADDR_AUX_FRAC, 12'hE3A);
    check("auxFraction", 12'h23A, 12'(auxFraction));
    wr(4'h1, 12'h803, 17);
    wr(ADDR_GAIN, 12'h00C, 15);
    wr(4'h1, 12'h006);
    check("auxDivIndex", 12'h1FF, 12'(auxDivIndex));
  endtask : t_aux

  task automatic t_refdiv();
    wr(ADDR_REF_DIV, 12'h05F);
    check("refIndices", 12'h05F, 12'({auxRefIndex, mainRefIndex}));
    ratio(1'b0, 32);
    ratio(1'b1, 3);
  endtask : t_refdiv

  task automatic t_gain();
    mainLocked = 1'b1;
    wr(ADDR_GAIN, 12'h54A);
    check("gains", 12'h2AA, 12'({auxGain, mainGain}));
    check("mainPin", 12'h001, 12'({mainPinO, mainPinOe}));
    check("auxPin", 12'h000, 12'({auxPinO, auxPinOe}));
    mainSteer = 1'b1;
    auxSteer = 1'b1;
    wr(ADDR_GAIN, 12'hFFF);
    check("gains", 12'h3FF, 12'({auxGain, mainGain}));
    check("mainPin", 12'h003, 12'({mainPinO, mainPinOe}));
    check("auxPin", 12'h003, 12'({auxPinO, auxPinOe}));
  endtask : t_gain

  task automatic t_power();
    for (int b = 0; b < 6; b++) begin
      wr(ADDR_POWER, 12'h001 << b);
      check("powerFlags", (12'h001 << b) | ((b == 0) ? 12'h012 : 12'h000),
        12'({auxIntegerMode, auxPowerDown, mainFrac10Bit, mainIntegerMode,
        mainPowerDown, fullPowerDown}));
    end
  endtask : t_power

  task automatic t_monitor();
    wr(ADDR_POWER, 12'h1C0);
    check("monitor", 12'h001, 12'({monitorOut, monitorOutEn}));
    wr(ADDR_POWER, 12'h000);
    @(posedge refOsc);
    repeat (5) @(negedge core_clk);
    check("monitor", 12'h003, 12'({monitorOut, monitorOutEn}));
    main_detector_freq = 1'b1;
    wr(ADDR_POWER, 12'h100);
    check("monitor", 12'h003, 12'({monitorOut, monitorOutEn}));
    wr(ADDR_POWER, 12'h0C0);
    check("monitor", 12'h001, 12'({monitorOut, monitorOutEn}));
    wr(ADDR_POWER, 12'h040);
    ratio(2, 3);
    wr(ADDR_POWER, 12'h080);
    ratio(2, 32);
    wr(ADDR_POWER, 12'h140);
    check("monitor", 12'h001, 12'({monitorOut, monitorOutEn}));
    wr(4'h8, 12'h000);
    check("monitor", 12'h003, 12'({monitorOut, monitorOutEn}));
    wr(ADDR_POWER, 12'h200);
    check("monitorOutEn", 12'h000, 12'(monitorOutEn));
  endtask : t_monitor

  task automatic tally_and_finish();
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial begin
    arst_n = 1'b0;
    mainLocked = 1'b0;
    auxLocked = 1'b0;
    mainSteer = 1'b0;
    auxSteer = 1'b0;
    main_detector_freq = 1'b0;
    aux_detector_freq = 1'b0;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_reset();
    t_aux();
    t_refdiv();
    t_gain();
    t_power();
    t_monitor();
    tally_and_finish();
  end
  initial begin
    #300us;
    miscompares++;
    tally_and_finish();
  end
endmodule : testbench
